// ===== shared/codec_homing_pkg.sv
// Shared constants and carrier types for the codec homing control block
`default_nettype none

package codec_homing_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Stream word format
	localparam int SAMPLE_W = 16;

	typedef struct packed {
		logic valid;
		logic last;
		logic [SAMPLE_W-1:0] data;
	} word_beat_t;

	localparam word_beat_t BEAT_IDLE = '{valid: 1'b0, last: 1'b0, data: 16'h0000};

	////////////////////////////////////////////////////////////////////////////
	// Encoder side: speech frames of fixed length
	localparam int ENC_FRAME_LEN = 160;
	localparam int ENC_IDX_W = 8;
	// Thirteen-bit value one, left-justified in a sixteen-bit word
	localparam logic [SAMPLE_W-1:0] ENC_HOME_SAMPLE = 16'h0008;

	////////////////////////////////////////////////////////////////////////////
	// Decoder side: parameter frames padded to a fixed word count
	localparam int MODE_COUNT = 8;
	localparam int MODE_W = 3;
	localparam int DEC_FRAME_WORDS = 16;
	localparam int DEC_IDX_W = 5;
	localparam int PAR_IDX_W = 4;

	// Homing parameter frames per rate mode, zero-padded; filled in at integration
	localparam logic [MODE_COUNT-1:0][DEC_FRAME_WORDS-1:0][SAMPLE_W-1:0] DEC_HOME_PATTERN = '0;

	// Words holding the prediction and first-subframe parameters, per mode
	localparam logic [MODE_COUNT-1:0][DEC_IDX_W-1:0] DEC_EARLY_WORDS = {MODE_COUNT{5'h04}};

	////////////////////////////////////////////////////////////////////////////
	// Output buffer of decoded speech
	localparam int FIFO_DEPTH = 16;

	// Home state after reset
	localparam logic HOME_AT_RESET = 1'b1;

endpackage : codec_homing_pkg

`default_nettype wire

// ===== core/stream_fifo.sv
// Shift-register FIFO with registered head and registered ready
`default_nettype none

module stream_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] data;
		logic [DEPTH-1:0] vld;
		logic in_rdy;
	} fifo_state_t;

	localparam fifo_state_t FIFO_RESET = '{data: '0, vld: '0, in_rdy: 1'b1};

	fifo_state_t s;
	fifo_state_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// Head always sits in entry zero, so the output needs no read mux
	always_comb begin
		logic placed;
		placed = 1'b0;
		next_s = s;
		if (out_ready && s.vld[0]) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_s.data[i] = s.data[i+1];
				next_s.vld[i] = s.vld[i+1];
			end
			next_s.vld[DEPTH-1] = 1'b0;
		end
		if (in_valid && s.in_rdy) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!placed && !next_s.vld[i]) begin
					next_s.data[i] = in_data;
					next_s.vld[i] = 1'b1;
					placed = 1'b1;
				end
			end
		end
		next_s.in_rdy = !next_s.vld[DEPTH-1];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s <= FIFO_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign in_ready = s.in_rdy;
	assign out_valid = s.vld[0];
	assign out_data = s.data[0];

endmodule : stream_fifo

`default_nettype wire

// ===== core/frame_matcher.sv
// Frame segmentation counter with whole-frame and leading-part comparison
`default_nettype none

module frame_matcher #(
	parameter int LEN = 160,
	parameter int IW = 8
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [15:0] in_data,
	input wire logic [15:0] expect_word,
	input wire logic [IW-1:0] early_len,
	output logic [IW-1:0] idx,
	output logic frame_end,
	output logic full_hit,
	output logic early_hit
);

	localparam logic [IW-1:0] LAST_IDX = IW'(LEN - 1);

	typedef struct packed {
		logic [IW-1:0] idx;
		logic ok_full;
		logic ok_early;
	} match_state_t;

	localparam match_state_t MATCH_RESET = '{idx: '0, ok_full: 1'b1, ok_early: 1'b1};

	match_state_t s;
	match_state_t next_s;
	logic word_ok;
	logic in_early;

	////////////////////////////////////////////////////////////////////////////
	// Hits are valid on the beat that closes the frame
	assign word_ok = (in_data == expect_word);
	assign in_early = (s.idx < early_len);
	assign frame_end = in_valid && (s.idx == LAST_IDX);
	assign full_hit = s.ok_full && word_ok;
	assign early_hit = s.ok_early && (word_ok || !in_early);
	assign idx = s.idx;

	always_comb begin
		next_s = s;
		if (frame_end) begin
			next_s = MATCH_RESET;
		end else if (in_valid) begin
			next_s.idx = s.idx + 1'b1;
			next_s.ok_full = s.ok_full && word_ok;
			next_s.ok_early = s.ok_early && (word_ok || !in_early);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s <= MATCH_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

endmodule : frame_matcher

`default_nettype wire

// ===== core/codec_homing_control.sv
// In-band homing detection and home-state control for encoder and decoder
`default_nettype none

module codec_homing_control (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [codec_homing_pkg::MODE_W-1:0] rate_mode,
	input wire codec_homing_pkg::word_beat_t enc_in,
	output codec_homing_pkg::word_beat_t enc_core,
	input wire codec_homing_pkg::word_beat_t enc_par,
	output codec_homing_pkg::word_beat_t enc_out,
	output logic enc_home_reset,
	output logic enc_homed,
	input wire codec_homing_pkg::word_beat_t dec_in,
	output codec_homing_pkg::word_beat_t dec_core,
	input wire codec_homing_pkg::word_beat_t dec_sp,
	output logic dec_sp_ready,
	output logic dec_out_valid,
	output logic [codec_homing_pkg::SAMPLE_W-1:0] dec_out_data,
	input wire logic dec_out_ready,
	output logic dec_home_reset,
	output logic dec_homed
);

	typedef struct packed {
		codec_homing_pkg::word_beat_t enc_core;
		codec_homing_pkg::word_beat_t enc_out;
		logic [codec_homing_pkg::PAR_IDX_W-1:0] enc_par_idx;
		logic enc_home;
		logic enc_pend_hit;
		logic enc_home_reset;
		codec_homing_pkg::word_beat_t dec_core;
		logic dec_home;
		logic dec_pend_hit;
		logic dec_home_reset;
	} ctl_state_t;

	localparam ctl_state_t CTL_RESET = '{
		enc_core: codec_homing_pkg::BEAT_IDLE,
		enc_out: codec_homing_pkg::BEAT_IDLE,
		enc_par_idx: '0,
		enc_home: codec_homing_pkg::HOME_AT_RESET,
		enc_pend_hit: 1'b0,
		enc_home_reset: 1'b0,
		dec_core: codec_homing_pkg::BEAT_IDLE,
		dec_home: codec_homing_pkg::HOME_AT_RESET,
		dec_pend_hit: 1'b0,
		dec_home_reset: 1'b0
	};

	ctl_state_t s;
	ctl_state_t next_s;

	logic [codec_homing_pkg::ENC_IDX_W-1:0] enc_idx;
	logic enc_frame_end;
	logic enc_full_hit;
	logic [codec_homing_pkg::DEC_IDX_W-1:0] dec_idx;
	logic dec_frame_end;
	logic dec_full_hit;
	logic dec_early_hit;
	logic [codec_homing_pkg::SAMPLE_W-1:0] dec_expect;
	logic [codec_homing_pkg::SAMPLE_W-1:0] enc_pattern_word;
	logic enc_substitute;
	logic dec_substitute;
	logic [codec_homing_pkg::SAMPLE_W-1:0] dec_push_data;
	logic dec_sp_take;
	logic fifo_in_ready;

	////////////////////////////////////////////////////////////////////////////
	// Frame detectors
	frame_matcher #(
		.LEN(codec_homing_pkg::ENC_FRAME_LEN),
		.IW(codec_homing_pkg::ENC_IDX_W)
	) enc_match (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.in_valid(enc_in.valid),
		.in_data(enc_in.data),
		.expect_word(codec_homing_pkg::ENC_HOME_SAMPLE),
		.early_len(8'(codec_homing_pkg::ENC_FRAME_LEN)),
		.idx(enc_idx),
		.frame_end(enc_frame_end),
		.full_hit(enc_full_hit),
		.early_hit()
	);

	assign dec_expect =
		codec_homing_pkg::DEC_HOME_PATTERN[rate_mode][dec_idx[codec_homing_pkg::PAR_IDX_W-1:0]];

	frame_matcher #(
		.LEN(codec_homing_pkg::DEC_FRAME_WORDS),
		.IW(codec_homing_pkg::DEC_IDX_W)
	) dec_match (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.in_valid(dec_in.valid),
		.in_data(dec_in.data),
		.expect_word(dec_expect),
		.early_len(codec_homing_pkg::DEC_EARLY_WORDS[rate_mode]),
		.idx(dec_idx),
		.frame_end(dec_frame_end),
		.full_hit(dec_full_hit),
		.early_hit(dec_early_hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// Speech output buffer; its ready stalls the decoder core
	stream_fifo #(
		.W(codec_homing_pkg::SAMPLE_W),
		.DEPTH(codec_homing_pkg::FIFO_DEPTH)
	) dec_buf (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.in_valid(dec_sp.valid),
		.in_data(dec_push_data),
		.in_ready(fifo_in_ready),
		.out_valid(dec_out_valid),
		.out_data(dec_out_data),
		.out_ready(dec_out_ready)
	);

	assign enc_pattern_word =
		codec_homing_pkg::DEC_HOME_PATTERN[rate_mode][s.enc_par_idx];
	assign enc_substitute = s.enc_home && s.enc_pend_hit;
	assign dec_substitute = s.dec_home && s.dec_pend_hit;
	assign dec_push_data = dec_substitute ? codec_homing_pkg::ENC_HOME_SAMPLE : dec_sp.data;
	assign dec_sp_take = dec_sp.valid && fifo_in_ready;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_s = s;
		next_s.enc_home_reset = 1'b0;
		next_s.dec_home_reset = 1'b0;

		// Samples reach the encoder unchanged, homing or not
		next_s.enc_core = enc_in;
		next_s.enc_core.last = enc_frame_end;
		if (enc_frame_end) begin
			next_s.enc_pend_hit = enc_full_hit;
		end

		next_s.enc_out = enc_par;
		if (enc_par.valid) begin
			next_s.enc_par_idx = enc_par.last ? '0 : s.enc_par_idx + 1'b1;
			if (enc_substitute) begin
				next_s.enc_out.data = enc_pattern_word;
			end
			if (enc_par.last) begin
				// Home state follows the frame just emitted
				next_s.enc_home = s.enc_pend_hit;
				next_s.enc_home_reset = s.enc_pend_hit;
			end
		end

		next_s.dec_core = dec_in;
		next_s.dec_core.last = dec_frame_end;
		if (dec_frame_end) begin
			// Short compare only trusted when already homed
			next_s.dec_pend_hit = s.dec_home ? dec_early_hit : dec_full_hit;
		end

		if (dec_sp_take && dec_sp.last) begin
			// Reset lands only on the last speech sample of the frame
			next_s.dec_home = s.dec_pend_hit;
			next_s.dec_home_reset = s.dec_pend_hit;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s <= CTL_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign enc_core = s.enc_core;
	assign enc_out = s.enc_out;
	assign enc_home_reset = s.enc_home_reset;
	assign enc_homed = s.enc_home;
	assign dec_core = s.dec_core;
	assign dec_sp_ready = fifo_in_ready;
	assign dec_home_reset = s.dec_home_reset;
	assign dec_homed = s.dec_home;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence enc_homing_last_beat;
		ce && enc_par.valid && enc_par.last && s.enc_pend_hit;
	endsequence

	sequence dec_homing_last_sample;
		ce && dec_sp_take && dec_sp.last && s.dec_pend_hit;
	endsequence

	a_enc_pass_through: assert property (@(posedge sys_clk) disable iff (srst)
		ce && enc_in.valid |=> enc_core.valid && enc_core.data == $past(enc_in.data))
	else $error("encoder input sample altered");

	a_enc_pattern_sub: assert property (@(posedge sys_clk) disable iff (srst)
		ce && enc_par.valid && s.enc_home && s.enc_pend_hit
		|=> enc_out.valid && enc_out.data == $past(enc_pattern_word))
	else $error("homed encoder did not emit homing parameters");

	a_enc_param_pass: assert property (@(posedge sys_clk) disable iff (srst)
		ce && enc_par.valid && !(s.enc_home && s.enc_pend_hit)
		|=> enc_out.data == $past(enc_par.data))
	else $error("encoder parameters altered outside homing");

	a_enc_home_reset: assert property (@(posedge sys_clk) disable iff (srst)
		enc_homing_last_beat |=> enc_home_reset && enc_homed ##1 !enc_home_reset)
	else $error("encoder home reset not a single pulse after homing frame");

	a_enc_run_homed: assert property (@(posedge sys_clk) disable iff (srst)
		ce && enc_frame_end && enc_full_hit && s.enc_home
		|=> s.enc_pend_hit && s.enc_home)
	else $error("consecutive encoder homing frame not substituted");

	a_enc_sample_value: assert property (@(posedge sys_clk) disable iff (srst)
		ce && enc_frame_end && enc_full_hit |-> enc_in.data == 16'h0008)
	else $error("encoder homing detected on wrong sample value");

	a_dec_mode_gate: assert property (@(posedge sys_clk) disable iff (srst)
		ce && dec_frame_end && !s.dec_home && !dec_full_hit |=> !s.dec_pend_hit)
	else $error("decoder homing started on foreign pattern");

	a_dec_speech_sub: assert property (@(posedge sys_clk) disable iff (srst)
		ce && dec_sp_take && s.dec_home && s.dec_pend_hit
		|-> dec_push_data == codec_homing_pkg::ENC_HOME_SAMPLE)
	else $error("homed decoder speech not replaced");

	a_dec_home_reset: assert property (@(posedge sys_clk) disable iff (srst)
		dec_homing_last_sample |=> dec_home_reset && dec_homed)
	else $error("decoder home reset missing after homing frame");

	a_dec_run_homed: assert property (@(posedge sys_clk) disable iff (srst)
		ce && dec_frame_end && dec_early_hit && s.dec_home
		|=> s.dec_pend_hit && s.dec_home)
	else $error("consecutive decoder homing frame not recognised");

	a_dec_early_cmp: assert property (@(posedge sys_clk) disable iff (srst)
		ce && dec_frame_end && s.dec_home |=> s.dec_pend_hit == $past(dec_early_hit))
	else $error("homed decoder decision not from leading parameters");

	a_dec_reset_edge: assert property (@(posedge sys_clk) disable iff (srst)
		dec_home_reset |-> $past(dec_sp.valid && dec_sp.last && ce))
	else $error("decoder home reset away from frame boundary");

endmodule : codec_homing_control

`default_nettype wire

// ===== sim/codec_far_model.sv
// Far-side model: encoder core and decoder core stand-ins answering each frame
`default_nettype none

module codec_far_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire codec_homing_pkg::word_beat_t enc_core,
	input wire codec_homing_pkg::word_beat_t dec_core,
	input wire logic dec_sp_ready,
	input wire logic [15:0] par_word,
	input wire logic [15:0] sp_word,
	input var int sp_len,
	output codec_homing_pkg::word_beat_t enc_par,
	output codec_homing_pkg::word_beat_t dec_sp
);
	timeunit 1ns;
	timeprecision 1ns;

	int par_left;
	int sp_left;

	////////////////////////////////////////////////////////////////////////////
	// Idle lines toggle so a stale value never looks like a fresh word
	always @(posedge sys_clk) begin
		if (srst) begin
			par_left = 0;
			sp_left = 0;
			enc_par <= codec_homing_pkg::BEAT_IDLE;
			dec_sp <= codec_homing_pkg::BEAT_IDLE;
		end else begin
			if (enc_core.valid && enc_core.last)
				par_left = 16;
			if (par_left > 0) begin
				enc_par <= '{valid: 1'b1, last: (par_left == 1), data: par_word};
				par_left--;
			end else
				enc_par <= '{valid: 1'b0, last: 1'b0, data: ~enc_par.data};
			// Speech held until taken; a full buffer stalls it
			if (dec_sp.valid && dec_sp_ready)
				sp_left--;
			if (dec_core.valid && dec_core.last)
				sp_left = sp_len;
			if (sp_left > 0)
				dec_sp <= '{valid: 1'b1, last: (sp_left == 1), data: sp_word};
			else
				dec_sp <= '{valid: 1'b0, last: 1'b0, data: ~dec_sp.data};
		end
	end

endmodule : codec_far_model

`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the codec homing control block
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic dec;
		logic [2:0] mode;
		logic [15:0] w_early;
		logic [15:0] w_late;
		logic sub;
		logic pulse;
		logic homed;
	} row_t;

	localparam logic [15:0] PAR_WORD = 16'h1234;
	localparam logic [15:0] SP_WORD = 16'ha5a5;

	// Decoder: early words 0..3, late word 10; encoder: samples 0..158, sample 159
	row_t rows [12] = '{
		'{1'b0, 3'h0, 16'h0100, 16'h0100, 1'b0, 1'b0, 1'b0},
		'{1'b0, 3'h1, 16'h0008, 16'h0008, 1'b0, 1'b1, 1'b1},
		'{1'b0, 3'h2, 16'h0008, 16'h0008, 1'b1, 1'b1, 1'b1},
		'{1'b0, 3'h3, 16'h0008, 16'h0009, 1'b0, 1'b0, 1'b0},
		'{1'b1, 3'h0, 16'h0001, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{1'b1, 3'h1, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1},
		'{1'b1, 3'h2, 16'h0000, 16'h0000, 1'b1, 1'b1, 1'b1},
		'{1'b1, 3'h3, 16'h0000, 16'h0001, 1'b1, 1'b1, 1'b1},
		'{1'b1, 3'h4, 16'h0001, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{1'b1, 3'h5, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b0},
		'{1'b1, 3'h6, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1},
		'{1'b1, 3'h7, 16'h0000, 16'h0000, 1'b1, 1'b1, 1'b1}
	};

	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic [2:0] rate_mode = 3'h0;
	logic dec_out_ready = 1'b1;
	codec_homing_pkg::word_beat_t enc_in = codec_homing_pkg::BEAT_IDLE;
	codec_homing_pkg::word_beat_t dec_in = codec_homing_pkg::BEAT_IDLE;
	codec_homing_pkg::word_beat_t enc_core, enc_par, enc_out, dec_core, dec_sp;
	logic dec_sp_ready, dec_out_valid, enc_home_reset, enc_homed, dec_home_reset, dec_homed;
	logic [15:0] dec_out_data;
	int sp_len = 8;
	int n_fail = 0;
	int samples_checked = 0;
	int n_enc_rst = 0;
	int n_dec_rst = 0;
	logic [15:0] enc_q [$];
	logic [15:0] dec_q [$];

	always #50 sys_clk = ~sys_clk;

	codec_homing_control i_codec_homing_control (.sys_clk(sys_clk), .srst(srst), .ce(ce),
		.rate_mode(rate_mode), .enc_in(enc_in), .enc_core(enc_core), .enc_par(enc_par),
		.enc_out(enc_out), .enc_home_reset(enc_home_reset), .enc_homed(enc_homed),
		.dec_in(dec_in), .dec_core(dec_core), .dec_sp(dec_sp), .dec_sp_ready(dec_sp_ready),
		.dec_out_valid(dec_out_valid), .dec_out_data(dec_out_data),
		.dec_out_ready(dec_out_ready), .dec_home_reset(dec_home_reset), .dec_homed(dec_homed));

	codec_far_model i_codec_far_model (.sys_clk(sys_clk), .srst(srst), .enc_core(enc_core),
		.dec_core(dec_core), .dec_sp_ready(dec_sp_ready), .par_word(PAR_WORD),
		.sp_word(SP_WORD), .sp_len(sp_len), .enc_par(enc_par), .dec_sp(dec_sp));

	////////////////////////////////////////////////////////////////////////////
	// Output monitor
	always @(posedge sys_clk) begin
		if (!srst) begin
			if (enc_out.valid)
				enc_q.push_back(enc_out.data);
			if (dec_out_valid && dec_out_ready)
				dec_q.push_back(dec_out_data);
			if (enc_home_reset)
				n_enc_rst++;
			if (dec_home_reset)
				n_dec_rst++;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks and stimulus
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : chk_flag

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic run_row(input row_t r);
		int i;
		int w;
		logic [15:0] v;
		logic [15:0] e;
		@(negedge sys_clk);
		rate_mode = r.mode;
		enc_q.delete();
		dec_q.delete();
		n_enc_rst = 0;
		n_dec_rst = 0;
		for (i = 0; i < (r.dec ? 16 : 160); i++) begin
			if (r.dec)
				dec_in = '{valid: 1'b1, last: 1'b0,
					data: (i < 4) ? r.w_early : ((i == 10) ? r.w_late : 16'h0000)};
			else
				enc_in = '{valid: 1'b1, last: 1'b0, data: (i == 159) ? r.w_late : r.w_early};
			@(negedge sys_clk);
		end
		enc_in = '{valid: 1'b0, last: 1'b0, data: ~enc_in.data};
		dec_in = '{valid: 1'b0, last: 1'b0, data: ~dec_in.data};
		w = 0;
		while ((r.dec ? dec_q.size() < sp_len : enc_q.size() < 16) && w < 400) begin
			@(negedge sys_clk);
			w++;
		end
		repeat (4) @(negedge sys_clk);
		chk_flag(w < 400, 1'b1);
		for (i = 0; i < (r.dec ? sp_len : 16); i++) begin
			v = r.dec ? dec_q[i] : enc_q[i];
			if (r.dec)
				e = r.sub ? codec_homing_pkg::ENC_HOME_SAMPLE : SP_WORD;
			else
				e = r.sub ? codec_homing_pkg::DEC_HOME_PATTERN[r.mode][i] : PAR_WORD;
			chk_word(v, e);
		end
		chk_word(16'(r.dec ? n_dec_rst : n_enc_rst), {15'h0000, r.pulse});
		chk_flag(r.dec ? dec_homed : enc_homed, r.homed);
		$display("Frame done: dec %b mode %0d", r.dec, r.mode);
	endtask : run_row

	initial begin
		repeat (5) @(negedge sys_clk);
		srst = 1'b0;
		chk_flag(enc_homed, codec_homing_pkg::HOME_AT_RESET);
		chk_flag(dec_homed, codec_homing_pkg::HOME_AT_RESET);
		chk_flag(dec_sp_ready, 1'b1);
		chk_flag(dec_out_valid, 1'b0);
		$display("Reset test done");
		// First decoder row differs in the early words
		foreach (rows[k])
			run_row(rows[k]);
		// Stalled sink: buffer fills until it refuses, then drains in order
		sp_len = 20;
		dec_out_ready = 1'b0;
		fork
			run_row('{1'b1, 3'h2, 16'h0001, 16'h0000, 1'b0, 1'b0, 1'b0});
			begin
				repeat (60) @(negedge sys_clk);
				chk_flag(dec_sp_ready, 1'b0);
				chk_flag(dec_out_valid, 1'b1);
				dec_out_ready = 1'b1;
			end
		join
		// Reset in mid-run restores both home states
		@(negedge sys_clk);
		srst = 1'b1;
		@(negedge sys_clk);
		srst = 1'b0;
		chk_flag(enc_homed, 1'b1);
		chk_flag(dec_homed, 1'b1);
		// Beats offered with the enable low are lost, so frame alignment must hold
		ce = 1'b0;
		enc_in = '{valid: 1'b1, last: 1'b0, data: 16'h0100};
		repeat (2) @(negedge sys_clk);
		chk_flag(enc_core.valid, 1'b0);
		chk_flag(enc_homed, 1'b1);
		enc_in = codec_homing_pkg::BEAT_IDLE;
		ce = 1'b1;
		$display("Clock enable test done");
		run_row('{1'b0, 3'h5, 16'h0008, 16'h0008, 1'b1, 1'b1, 1'b1});
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end

endmodule : testbench

`default_nettype wire
